// file: rtl/cmd_word_defines.svh
`ifndef CMD_WORD_DEFINES_SVH
`define CMD_WORD_DEFINES_SVH
`define CW_WIDTH 16
`define CW_RAMP_STOP 0
`define CW_COAST_STOP 1
`define CW_QUICK_STOP 2
`define CW_RUN 3
`define CW_RAMP_OUT 4
`define CW_RAMP_HOLD 5
`define CW_RAMP_IN 6
`define CW_FAULT_RESET 7
`define CW_INCH1 8
`define CW_REMOTE 10
`define CW_LOC_SEL 11
`define CW_LOCAL_MASK 16'h0007
`define CW_RESET_VAL 16'h0000
`endif

// file: rtl/cmd_word_pkg.sv
package cmd_word_pkg;
    typedef enum logic [3:0] {
        ST_SWITCH_ON_INHIBITED = 4'h0,
        ST_READY_TO_SWITCH_ON = 4'h1,
        ST_READY_TO_OPERATE = 4'h2,
        ST_OPERATION_ENABLED = 4'h3,
        ST_OPERATION_INHIBITED = 4'h4,
        ST_RAMP_STOP_ACTIVE = 4'h5,
        ST_COAST_STOP_ACTIVE = 4'h6,
        ST_QUICK_STOP_ACTIVE = 4'h7,
        ST_FAULT = 4'h8
    } drive_state_t;

    typedef struct packed {
        logic ramp_out_enable;
        logic ramp_accel_enable;
        logic ramp_in_enable;
        logic inching1;
    } ramp_ctl_t;

    typedef struct packed {
        drive_state_t state;
        logic [15:0] word;
        logic reset_bit_prev;
        logic run_enable;
        logic fault_reset_pulse;
        logic loc_two;
        ramp_ctl_t ramp;
        logic coast_stop_ctl;
        logic quick_stop_ctl;
        logic ramp_stop_ctl;
    } dec_state_t;
endpackage : cmd_word_pkg

// file: rtl/fieldbus_control_word_decoder.sv
// Functional notes
// - Bit 0 high advances the state machine to ready-to-operate.
// - Bit 0 low ramp-stops via ramp-stop-active to ready-to-switch-on.
// - Bit 1 high keeps operating, coast-stop interlock inactive.
// - Bit 1 low coasts via coast-stop-active to switch-on-inhibited.
// - Bit 2 high keeps operating, quick-stop interlock inactive.
// - Bit 2 low quick-stops via quick-stop-active to switch-on-inhibited.
// - Bit 3 high advances to operation-enabled.
// - Operation-enabled needs run-enable; bit 3 drives it when fieldbus-sourced.
// - Bit 3 low moves to operation-inhibited.
// - Bit 4 high enables the ramp generator output.
// - Bit 4 low forces ramp output to zero.
// - Bit 5 high enables ramp accelerating function.
// - Bit 5 low holds the ramp output.
// - Bit 6 high runs normally, only when fieldbus is its source.
// - Bit 6 low forces ramp input to zero.
// - Bit 7 rising edge clears fault, goes to switch-on-inhibited.
// - Fault reset honoured only when fieldbus is reset source.
// - Bit 8 high selects inching setpoint one; master keeps bits 4-6 low.
// - Bit 10 low ignores the word except bits 0 to 2.
// - Bit 11 selects external location two or one when fieldbus chooses.
`timescale 1ns/100ps
`include "cmd_word_defines.svh"
module fieldbus_control_word_decoder
    import cmd_word_pkg::*;
#(
    parameter int WORD_WIDTH = `CW_WIDTH
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [WORD_WIDTH-1:0] fieldbus_command_word,
    input wire logic word_valid,
    input wire logic run_enable_from_fieldbus,
    input wire logic run_enable_ext,
    input wire logic ramp_in_from_fieldbus,
    input wire logic reset_from_fieldbus,
    input wire logic loc_from_fieldbus,
    input wire logic fault_active,
    input wire logic stop_done,
    output logic [3:0] drive_state,
    output logic run_enable,
    output logic fault_reset,
    output logic ramp_out_enable,
    output logic ramp_accel_enable,
    output logic ramp_in_enable,
    output logic inching1,
    output logic external_location_two,
    output logic coast_stop_ctl,
    output logic quick_stop_ctl,
    output logic ramp_stop_ctl
);
    if (WORD_WIDTH != 16) begin : g_width_check
        $error("fieldbus command word must be 16 bits");
    end

    dec_state_t s_reg;
    dec_state_t s_next;
    logic [15:0] w;
    logic remote;
    logic run_ok;

    // Merge a new word; outside remote control only the stop bits get through
    function automatic logic [15:0] merge_word(input logic [15:0] held, input logic [15:0] nw);
        logic rem;
        rem = nw[`CW_REMOTE];
        if (rem) begin
            merge_word = nw;
        end else begin
            merge_word = (held & ~`CW_LOCAL_MASK) | (nw & `CW_LOCAL_MASK);
            // The remote bit follows the master, or remote control could never be left again
            merge_word[`CW_REMOTE] = 1'b0;
        end
    endfunction : merge_word

    always_comb begin
        s_next = s_reg;
        w = s_reg.word;
        s_next.fault_reset_pulse = 1'b0;
        if (word_valid) begin
            w = merge_word(s_reg.word, fieldbus_command_word);
            s_next.word = w;
            s_next.reset_bit_prev = w[`CW_FAULT_RESET];
        end
        remote = w[`CW_REMOTE];
        s_next.coast_stop_ctl = ~w[`CW_COAST_STOP];
        s_next.quick_stop_ctl = ~w[`CW_QUICK_STOP];
        s_next.ramp_stop_ctl = ~w[`CW_RAMP_STOP];
        s_next.run_enable = run_enable_from_fieldbus ? w[`CW_RUN] : run_enable_ext;
        run_ok = s_next.run_enable;
        s_next.ramp.ramp_out_enable = w[`CW_RAMP_OUT] & remote;
        s_next.ramp.ramp_accel_enable = w[`CW_RAMP_HOLD] & remote;
        s_next.ramp.ramp_in_enable = ramp_in_from_fieldbus ? (w[`CW_RAMP_IN] & remote) : 1'b1;
        s_next.ramp.inching1 = w[`CW_INCH1] & remote;
        if (loc_from_fieldbus) begin
            s_next.loc_two = w[`CW_LOC_SEL] & remote;
        end
        if (word_valid && reset_from_fieldbus && remote && w[`CW_FAULT_RESET] && !s_reg.reset_bit_prev) begin
            s_next.fault_reset_pulse = 1'b1;
        end
        // State machine re-evaluated every cycle; stop priorities fixed
        if (s_reg.state == ST_FAULT) begin
            if (s_next.fault_reset_pulse) begin
                s_next.state = ST_SWITCH_ON_INHIBITED;
            end
        end else if (fault_active) begin
            s_next.state = ST_FAULT;
        end else if (!w[`CW_COAST_STOP]) begin
            if (s_reg.state == ST_COAST_STOP_ACTIVE && stop_done) begin
                s_next.state = ST_SWITCH_ON_INHIBITED;
            end else if (s_reg.state != ST_SWITCH_ON_INHIBITED) begin
                s_next.state = ST_COAST_STOP_ACTIVE;
            end
        end else if (!w[`CW_QUICK_STOP]) begin
            if (s_reg.state == ST_QUICK_STOP_ACTIVE && stop_done) begin
                s_next.state = ST_SWITCH_ON_INHIBITED;
            end else if (s_reg.state != ST_SWITCH_ON_INHIBITED) begin
                s_next.state = ST_QUICK_STOP_ACTIVE;
            end
        end else begin
            case (s_reg.state)
                ST_SWITCH_ON_INHIBITED: begin
                    // Stop bit must be low once before restart, so a held high word cannot auto-start
                    if (!w[`CW_RAMP_STOP]) begin
                        s_next.state = ST_READY_TO_SWITCH_ON;
                    end
                end
                ST_READY_TO_SWITCH_ON: begin
                    if (w[`CW_RAMP_STOP]) begin
                        s_next.state = ST_READY_TO_OPERATE;
                    end
                end
                ST_READY_TO_OPERATE, ST_OPERATION_INHIBITED: begin
                    if (!w[`CW_RAMP_STOP]) begin
                        s_next.state = ST_READY_TO_SWITCH_ON;
                    end else if (w[`CW_RUN] && run_ok && remote) begin
                        s_next.state = ST_OPERATION_ENABLED;
                    end else if (s_reg.state == ST_READY_TO_OPERATE && remote) begin
                        s_next.state = ST_OPERATION_INHIBITED;
                    end
                end
                ST_OPERATION_ENABLED: begin
                    if (!w[`CW_RAMP_STOP]) begin
                        s_next.state = ST_RAMP_STOP_ACTIVE;
                    end else if (!w[`CW_RUN] || !run_ok) begin
                        s_next.state = ST_OPERATION_INHIBITED;
                    end
                end
                ST_RAMP_STOP_ACTIVE: begin
                    if (stop_done) begin
                        s_next.state = ST_READY_TO_SWITCH_ON;
                    end
                end
                ST_COAST_STOP_ACTIVE, ST_QUICK_STOP_ACTIVE: begin
                    if (stop_done) begin
                        s_next.state = ST_SWITCH_ON_INHIBITED;
                    end
                end
                default: begin
                    s_next.state = ST_SWITCH_ON_INHIBITED;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_reg <= '{state: ST_SWITCH_ON_INHIBITED, word: `CW_RESET_VAL, reset_bit_prev: 1'b0,
                       run_enable: 1'b0, fault_reset_pulse: 1'b0, loc_two: 1'b0,
                       ramp: '{1'b0, 1'b0, 1'b0, 1'b0},
                       coast_stop_ctl: 1'b1, quick_stop_ctl: 1'b1, ramp_stop_ctl: 1'b1};
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign drive_state = s_reg.state;
    assign run_enable = s_reg.run_enable;
    assign fault_reset = s_reg.fault_reset_pulse;
    assign ramp_out_enable = s_reg.ramp.ramp_out_enable;
    assign ramp_accel_enable = s_reg.ramp.ramp_accel_enable;
    assign ramp_in_enable = s_reg.ramp.ramp_in_enable;
    assign inching1 = s_reg.ramp.inching1;
    assign external_location_two = s_reg.loc_two;
    assign coast_stop_ctl = s_reg.coast_stop_ctl;
    assign quick_stop_ctl = s_reg.quick_stop_ctl;
    assign ramp_stop_ctl = s_reg.ramp_stop_ctl;

    sequence s_coast_word;
        clk_en && word_valid && !fieldbus_command_word[`CW_COAST_STOP] && !fault_active
            && s_reg.state != ST_FAULT && s_reg.state != ST_SWITCH_ON_INHIBITED
            && !(s_reg.state == ST_COAST_STOP_ACTIVE && stop_done);
    endsequence
    sequence s_coast_entered;
        coast_stop_ctl && s_reg.state == ST_COAST_STOP_ACTIVE;
    endsequence

    property p_coast_entry;
        @(posedge ref_clk) disable iff (reset) s_coast_word |=> s_coast_entered;
    endproperty
    a_coast_entry: assert property (p_coast_entry) else $error("coast stop not entered");

    property p_coast_over_quick;
        @(posedge ref_clk) disable iff (reset)
            s_reg.state == ST_QUICK_STOP_ACTIVE |-> s_reg.word[`CW_COAST_STOP];
    endproperty
    a_coast_over_quick: assert property (p_coast_over_quick) else $error("quick stop while coast requested");

    property p_quick_to_inhibit;
        @(posedge ref_clk) disable iff (reset)
            clk_en && s_reg.state == ST_QUICK_STOP_ACTIVE && stop_done && !fault_active && w[`CW_COAST_STOP]
            |=> s_reg.state == ST_SWITCH_ON_INHIBITED;
    endproperty
    a_quick_to_inhibit: assert property (p_quick_to_inhibit) else $error("quick stop did not finish");

    property p_enabled_needs_run;
        @(posedge ref_clk) disable iff (reset)
            s_reg.state == ST_OPERATION_ENABLED && $past(s_reg.state) != ST_OPERATION_ENABLED
            |-> run_enable && s_reg.word[`CW_RUN];
    endproperty
    a_enabled_needs_run: assert property (p_enabled_needs_run) else $error("enabled without run enable");

    property p_fault_reset_edge;
        @(posedge ref_clk) disable iff (reset)
            fault_reset && $past(clk_en) |-> $past(s_reg.reset_bit_prev) == 1'b0 && s_reg.word[`CW_FAULT_RESET];
    endproperty
    a_fault_reset_edge: assert property (p_fault_reset_edge) else $error("fault reset without edge");

    property p_fault_cleared;
        @(posedge ref_clk) disable iff (reset)
            clk_en && s_reg.state == ST_FAULT && s_next.fault_reset_pulse |=> s_reg.state == ST_SWITCH_ON_INHIBITED;
    endproperty
    a_fault_cleared: assert property (p_fault_cleared) else $error("fault not cleared");

    property p_reset_source;
        @(posedge ref_clk) disable iff (reset) clk_en && !reset_from_fieldbus |=> !fault_reset;
    endproperty
    a_reset_source: assert property (p_reset_source) else $error("reset honoured from wrong source");

    property p_ramp_out;
        @(posedge ref_clk) disable iff (reset)
            clk_en && word_valid && fieldbus_command_word[`CW_REMOTE] ##1 1'b1 |-> ramp_out_enable == $past(fieldbus_command_word[`CW_RAMP_OUT]);
    endproperty
    a_ramp_out: assert property (p_ramp_out) else $error("ramp output enable wrong");

    property p_local_ignored;
        @(posedge ref_clk) disable iff (reset)
            clk_en && word_valid && !fieldbus_command_word[`CW_REMOTE] |=> !ramp_accel_enable && !inching1;
    endproperty
    a_local_ignored: assert property (p_local_ignored) else $error("word not ignored in local");

    sequence s_stops_clear;
        clk_en && !fault_active && w[`CW_COAST_STOP] && w[`CW_QUICK_STOP];
    endsequence

    property p_ready_to_operate;
        @(posedge ref_clk) disable iff (reset)
            s_stops_clear ##0 (s_reg.state == ST_READY_TO_SWITCH_ON && w[`CW_RAMP_STOP])
            |=> s_reg.state == ST_READY_TO_OPERATE;
    endproperty
    a_ready_to_operate: assert property (p_ready_to_operate) else $error("ready to operate not reached");

    property p_ramp_stop_entry;
        @(posedge ref_clk) disable iff (reset)
            s_stops_clear ##0 (s_reg.state == ST_OPERATION_ENABLED && !w[`CW_RAMP_STOP])
            |=> s_reg.state == ST_RAMP_STOP_ACTIVE;
    endproperty
    a_ramp_stop_entry: assert property (p_ramp_stop_entry) else $error("ramp stop not entered");

    property p_ramp_stop_done;
        @(posedge ref_clk) disable iff (reset)
            s_stops_clear ##0 (s_reg.state == ST_RAMP_STOP_ACTIVE && stop_done)
            |=> s_reg.state == ST_READY_TO_SWITCH_ON;
    endproperty
    a_ramp_stop_done: assert property (p_ramp_stop_done) else $error("ramp stop did not finish");

    property p_run_inhibit;
        @(posedge ref_clk) disable iff (reset)
            s_stops_clear ##0 (s_reg.state == ST_OPERATION_ENABLED && w[`CW_RAMP_STOP] && !w[`CW_RUN])
            |=> s_reg.state == ST_OPERATION_INHIBITED;
    endproperty
    a_run_inhibit: assert property (p_run_inhibit) else $error("operation not inhibited");

    property p_stop_ctl_map;
        @(posedge ref_clk) disable iff (reset)
            clk_en && word_valid |=> coast_stop_ctl == !$past(fieldbus_command_word[`CW_COAST_STOP])
                && quick_stop_ctl == !$past(fieldbus_command_word[`CW_QUICK_STOP]);
    endproperty
    a_stop_ctl_map: assert property (p_stop_ctl_map) else $error("stop controls do not follow word");

    property p_ramp_in_source;
        @(posedge ref_clk) disable iff (reset) clk_en && !ramp_in_from_fieldbus |=> ramp_in_enable;
    endproperty
    a_ramp_in_source: assert property (p_ramp_in_source) else $error("ramp input gated by wrong source");

    property p_ramp_in_zero;
        @(posedge ref_clk) disable iff (reset)
            clk_en && word_valid && fieldbus_command_word[`CW_REMOTE] && ramp_in_from_fieldbus
            |=> ramp_in_enable == $past(fieldbus_command_word[`CW_RAMP_IN]);
    endproperty
    a_ramp_in_zero: assert property (p_ramp_in_zero) else $error("ramp input enable wrong");

    property p_inching;
        @(posedge ref_clk) disable iff (reset)
            clk_en && word_valid && fieldbus_command_word[`CW_REMOTE]
            |=> inching1 == $past(fieldbus_command_word[`CW_INCH1]);
    endproperty
    a_inching: assert property (p_inching) else $error("inching output wrong");

    property p_loc_hold;
        @(posedge ref_clk) disable iff (reset) clk_en && !loc_from_fieldbus |=> $stable(external_location_two);
    endproperty
    a_loc_hold: assert property (p_loc_hold) else $error("location changed without fieldbus selection");

    property p_freeze;
        @(posedge ref_clk) disable iff (reset) !clk_en |=> $stable(s_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule : fieldbus_control_word_decoder

// file: verif/cw_master.sv
`timescale 1ns/100ps
module cw_master (
    input wire logic ref_clk,
    output logic [15:0] word,
    output logic valid
);
    logic [15:0] last;
    initial begin
        word = 16'h0000;
        valid = 1'b0;
        last = 16'h0000;
    end
    // Word and strobe change after a falling edge and hold across the taking edge
    task automatic send(input logic [15:0] w);
        @(negedge ref_clk);
        word = w;
        valid = 1'b1;
        last = w;
        @(posedge ref_clk);
        @(negedge ref_clk);
        valid = 1'b0;
        // Stale data between words must not match the last word by accident
        word = ~last;
    endtask : send
    task automatic send_inch(input logic [15:0] w);
        send(w & 16'hff8f);
    endtask : send_inch
    task automatic send_run(input logic [15:0] w);
        send(w | 16'h0008);
    endtask : send_run
endmodule : cw_master

// file: verif/tb.sv
`timescale 1ns/100ps
module tb;
    import cmd_word_pkg::*;
    logic ref_clk, reset, ce, rfb, rext, rin, rsf, lfb, fault_active, stop_done, valid;
    logic [15:0] word;
    logic [3:0] drive_state;
    logic run_enable, fault_reset, ramp_out_enable, ramp_accel_enable, ramp_in_enable, inching1;
    logic external_location_two, coast_stop_ctl, quick_stop_ctl, ramp_stop_ctl;
    logic [4:0] outs;
    int err_count = 0;
    int checks = 0;
    assign outs = {ramp_out_enable, ramp_accel_enable, ramp_in_enable, inching1, external_location_two};
    cw_master i_master (.ref_clk(ref_clk), .word(word), .valid(valid));
    fieldbus_control_word_decoder i_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(ce),
        .fieldbus_command_word(word), .word_valid(valid), .run_enable_from_fieldbus(rfb),
        .run_enable_ext(rext), .ramp_in_from_fieldbus(rin), .reset_from_fieldbus(rsf),
        .loc_from_fieldbus(lfb), .fault_active(fault_active), .stop_done(stop_done),
        .drive_state(drive_state), .run_enable(run_enable), .fault_reset(fault_reset),
        .ramp_out_enable(ramp_out_enable), .ramp_accel_enable(ramp_accel_enable),
        .ramp_in_enable(ramp_in_enable), .inching1(inching1), .external_location_two(external_location_two),
        .coast_stop_ctl(coast_stop_ctl), .quick_stop_ctl(quick_stop_ctl), .ramp_stop_ctl(ramp_stop_ctl));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic end_sim;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic wait_state(input logic [3:0] s);
        for (int i = 0; i < 20; i++) begin
            @(negedge ref_clk);
            if (drive_state === s) begin
                chk(drive_state, s, "state");
                return;
            end
        end
        chk(drive_state, s, "state wait timed out");
        end_sim();
    endtask : wait_state
    task automatic to_run;
        i_master.send(16'h0406);
        chk(drive_state, ST_READY_TO_SWITCH_ON, "ready to switch on");
        i_master.send(16'h0407);
        chk(drive_state, ST_READY_TO_OPERATE, "ready to operate");
        rfb = 1'b0;
        i_master.send(16'h047f);
        @(negedge ref_clk);
        chk(run_enable, 1'b0, "run enable without source");
        rfb = 1'b1;
        i_master.send_run(16'h0477);
        chk(run_enable, 1'b1, "run enable from word");
        chk(outs, 5'b11100, "ramp outputs on");
        wait_state(ST_OPERATION_ENABLED);
    endtask : to_run
    task automatic t_ramp;
        i_master.send(16'h046f);
        chk(outs, 5'b01100, "ramp out forced zero");
        i_master.send(16'h045f);
        chk(outs, 5'b10100, "ramp held");
        i_master.send(16'h043f);
        chk(outs, 5'b11000, "ramp in zero");
        rin = 1'b0;
        i_master.send(16'h043f);
        chk(outs, 5'b11100, "ramp in not fieldbus");
        rin = 1'b1;
        i_master.send(16'h0477);
        wait_state(ST_OPERATION_INHIBITED);
        i_master.send_inch(16'h057f);
        chk(outs, 5'b00010, "inching one");
        lfb = 1'b1;
        i_master.send(16'h0c07);
        chk(external_location_two, 1'b1, "location two");
        lfb = 1'b0;
        i_master.send(16'h0407);
        chk(external_location_two, 1'b1, "location held");
        lfb = 1'b1;
        i_master.send(16'h0407);
        chk(external_location_two, 1'b0, "location one");
        // Remote word with ramp bits set, so the local word below must really clear them
        i_master.send(16'h0477);
        chk(outs, 5'b11100, "ramp outputs before local");
        i_master.send(16'h097f);
        chk(outs, 5'b00000, "remote off");
        $display("ramp test done");
    endtask : t_ramp
    task automatic t_fault;
        fault_active = 1'b1;
        wait_state(ST_FAULT);
        rsf = 1'b0;
        i_master.send(16'h0407);
        i_master.send(16'h0487);
        chk(fault_reset, 1'b0, "reset not fieldbus");
        rsf = 1'b1;
        i_master.send(16'h0407);
        i_master.send(16'h0487);
        chk(fault_reset, 1'b1, "reset pulse");
        fault_active = 1'b0;
        @(negedge ref_clk);
        chk(fault_reset, 1'b0, "reset pulse one cycle");
        wait_state(ST_SWITCH_ON_INHIBITED);
        $display("fault test done");
    endtask : t_fault
    task automatic t_stop(input logic [15:0] w, input logic [3:0] st, input logic [3:0] fin, input logic [2:0] c);
        to_run();
        i_master.send(w);
        chk(drive_state, st, "stop state");
        chk({coast_stop_ctl, quick_stop_ctl, ramp_stop_ctl}, c, "stop controls");
        stop_done = 1'b1;
        wait_state(fin);
        stop_done = 1'b0;
        $display("stop test done");
    endtask : t_stop
    task automatic t_hold;
        to_run();
        ce = 1'b0;
        i_master.send(16'h0400);
        chk(drive_state, ST_OPERATION_ENABLED, "frozen state");
        chk({coast_stop_ctl, quick_stop_ctl, ramp_stop_ctl}, 3'b000, "frozen controls");
        ce = 1'b1;
        rfb = 1'b0;
        rext = 1'b1;
        i_master.send(16'h0477);
        chk(run_enable, 1'b1, "external run enable");
        chk(drive_state, ST_OPERATION_INHIBITED, "run bit low");
        rext = 1'b0;
        i_master.send(16'h047f);
        chk(drive_state, ST_OPERATION_INHIBITED, "no external run enable");
        rext = 1'b1;
        wait_state(ST_OPERATION_ENABLED);
        rfb = 1'b1;
        rext = 1'b0;
        reset = 1'b1;
        @(negedge ref_clk);
        reset = 1'b0;
        chk(drive_state, ST_SWITCH_ON_INHIBITED, "mid-run reset state");
        chk({coast_stop_ctl, quick_stop_ctl, ramp_stop_ctl, run_enable}, 4'he, "mid-run reset outputs");
        $display("hold test done");
    endtask : t_hold
    initial begin
        {rext, rin, rsf, lfb, fault_active, stop_done} = 6'h00;
        rfb = 1'b1;
        rin = 1'b1;
        ce = 1'b1;
        reset = 1'b1;
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
        chk(drive_state, ST_SWITCH_ON_INHIBITED, "reset state");
        chk({coast_stop_ctl, quick_stop_ctl, ramp_stop_ctl, run_enable}, 4'he, "reset outputs");
        to_run();
        t_ramp();
        t_fault();
        t_stop(16'h0400, ST_COAST_STOP_ACTIVE, ST_SWITCH_ON_INHIBITED, 3'b111);
        t_stop(16'h0403, ST_QUICK_STOP_ACTIVE, ST_SWITCH_ON_INHIBITED, 3'b010);
        t_stop(16'h0406, ST_RAMP_STOP_ACTIVE, ST_READY_TO_SWITCH_ON, 3'b001);
        t_hold();
        end_sim();
    end
endmodule : tb
